// ===== stm_defs.svh
// Offsets, field positions, reset values and counts of the trace block
// Assumes byte-wide registers on the processor port
`ifndef STM_DEFS_SVH
`define STM_DEFS_SVH
`define STM_OFS_CTRL      8'h38
`define STM_OFS_STAT      8'h39
`define STM_OFS_IADDR     8'h3a
`define STM_OFS_IDATA     8'h3b
`define STM_CTRL_RESET    8'h04
`define STM_CTRL_TRACE_LEN_SHORT    0
`define STM_CTRL_NOALIGN  1
`define STM_CTRL_TXNULL   2
`define STM_CTRL_PERSIST_FIVE_SEL     3
`define STM_CTRL_MMIE     4
`define STM_CTRL_UNIE     5
`define STM_CTRL_RXSEL    6
`define STM_STAT_MMV      0
`define STM_STAT_MMI      1
`define STM_STAT_UNV      2
`define STM_STAT_UNI      3
`define STM_STAT_BUSY     7
`define STM_IADDR_RD      7
`define STM_IADDR_PAGE    6
`define STM_LEN_SHORT     7'd16
`define STM_LEN_LONG      7'd64
`define STM_PERSIST_LO    3'd3
`define STM_PERSIST_HI    3'd5
`define STM_UNSTABLE_CNT  3'd6
`define STM_CHAR_CR       8'h0d
`define STM_CHAR_LF       8'h0a
`endif

// ===== stm_pkg.sv
// Types shared by the trace block and its users
// Assumes stm_defs.svh holds the numeric constants
package stm_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } stm_cpu_req_t;
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } stm_byte_t;
   typedef enum logic {STM_STABLE, STM_UNSTABLE} stm_stab_t;
endpackage : stm_pkg

// ===== stm_trace_ctrl.sv
// Section trace message capture, persistence, compare and transmit source
// Assumes one trace byte per frame on the receive side and a one-cycle
// request per frame from the transmit inserter, all on clk_sys
`timescale 1ns/100ps
`include "stm_defs.svh"
module stm_trace_ctrl #(
   parameter int MSG_DEPTH = 64
) (
   input  wire logic                 clk_sys,
   input  wire logic                 rst,
   input  wire stm_pkg::stm_cpu_req_t cpu_req,
   output      logic [7:0]           cpu_rdata,
   input  wire stm_pkg::stm_byte_t   rx_trace,
   input  wire logic                 tx_req,
   output      stm_pkg::stm_byte_t   tx_overhead_inserter,
   output      logic                 irq_n_out
);

   if (MSG_DEPTH != 64) begin : g_depth_check
      $error("MSG_DEPTH must be 64");
   end

   logic [7:0]        ctrl_reg;
   logic [6:0]        iaddr_reg;
   logic              irw_reg;
   logic [7:0]        idata_reg;
   logic              busy_reg;
   logic [7:0]        cap_mem [MSG_DEPTH];
   logic [7:0]        exp_mem [MSG_DEPTH];
   logic [7:0]        tx_mem  [MSG_DEPTH];
   logic [5:0]        wptr_reg;
   logic [5:0]        tptr_reg;
   logic [7:0]        prev1_reg;
   logic [7:0]        prev2_reg;
   logic              msg_diff_reg;
   logic [2:0]        same_cnt_reg;
   logic [2:0]        diff_cnt_reg;
   logic              accepted_reg;
   logic              mismatch_reg;
   logic              mm_flag_reg;
   logic              un_flag_reg;
   stm_pkg::stm_stab_t stab_reg;

   logic              len_short;
   logic              align_off;
   logic [2:0]        persist;
   logic              byte_in;
   logic              realign;
   logic [5:0]        wslot;
   logic              byte_diff;
   logic              msg_end;
   logic              msg_same;
   logic [2:0]        same_cnt_next;
   logic [2:0]        diff_cnt_next;
   logic              accept_now;
   logic              mismatch_next;
   logic              mm_change;
   logic              un_enter;
   logic              un_leave;
   logic              stat_rd;
   logic              iaddr_wr;

   // Last location of the selected message length
   function automatic logic is_last(input logic [5:0] p, input logic s);
      logic [6:0] len;
      len = s ? `STM_LEN_SHORT : `STM_LEN_LONG;
      is_last = ({1'b0, p} == len - 7'd1);
   endfunction : is_last

   // Pointer advance with wrap at the message length
   function automatic logic [5:0] ptr_inc(input logic [5:0] p,
                                          input logic       s);
      ptr_inc = is_last(p, s) ? 6'h00 : p + 6'h01;
   endfunction : ptr_inc

   assign len_short = ctrl_reg[`STM_CTRL_TRACE_LEN_SHORT];
   assign align_off = ctrl_reg[`STM_CTRL_NOALIGN];
   assign persist   = ctrl_reg[`STM_CTRL_PERSIST_FIVE_SEL] ? `STM_PERSIST_HI
                                               : `STM_PERSIST_LO;
   assign byte_in   = rx_trace.valid;
   assign stat_rd   = cpu_req.rd && (cpu_req.addr == `STM_OFS_STAT);
   assign iaddr_wr  = cpu_req.wr && (cpu_req.addr == `STM_OFS_IADDR);

   // Alignment marker detection
   always_comb begin
      realign = 1'b0;
      if (!align_off) begin
         if (len_short) begin
            realign = rx_trace.data[7];
         end else begin
            realign = (prev2_reg == `STM_CHAR_CR) &&
                      (prev1_reg == `STM_CHAR_LF);
         end
      end
   end

   assign wslot     = realign ? 6'h00 : wptr_reg;
   assign byte_diff = (cap_mem[wslot] != rx_trace.data);
   assign msg_end   = byte_in && is_last(wslot, len_short);
   assign msg_same  = !(msg_diff_reg || byte_diff) &&
                      !(realign && (wptr_reg != 6'h00));

   // Persistence and instability counting per completed message
   always_comb begin
      same_cnt_next = same_cnt_reg;
      diff_cnt_next = diff_cnt_reg;
      if (msg_same) begin
         diff_cnt_next = 3'd0;
         if (same_cnt_reg < `STM_PERSIST_HI) begin
            same_cnt_next = same_cnt_reg + 3'd1;
         end
      end else begin
         same_cnt_next = 3'd1;
         if (diff_cnt_reg < `STM_UNSTABLE_CNT) begin
            diff_cnt_next = diff_cnt_reg + 3'd1;
         end
      end
   end

   assign accept_now = msg_end && (same_cnt_next == persist)
                       && (same_cnt_reg != persist);

   // Capture page against expected page; used only while the
   // capture page still holds the accepted message
   always_comb begin
      mismatch_next = 1'b0;
      for (int i = 0; i < MSG_DEPTH; i++) begin
         if ((i < 16 || !len_short) && cap_mem[i] != exp_mem[i]) begin
            mismatch_next = 1'b1;
         end
      end
   end

   assign mm_change = accepted_reg && (mismatch_reg != mismatch_next);
   assign un_enter  = msg_end && (stab_reg == stm_pkg::STM_STABLE) &&
                      (diff_cnt_next == `STM_UNSTABLE_CNT);
   assign un_leave  = (stab_reg == stm_pkg::STM_UNSTABLE) &&
                      accept_now;

   // Control and indirect registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         ctrl_reg  <= `STM_CTRL_RESET;
         iaddr_reg <= 7'h00;
         irw_reg   <= 1'b0;
      end else if (cpu_req.wr) begin
         if (cpu_req.addr == `STM_OFS_CTRL) begin
            ctrl_reg <= {1'b0, cpu_req.wdata[6:0]};
         end
         if (iaddr_wr) begin
            iaddr_reg <= cpu_req.wdata[6:0];
            irw_reg   <= cpu_req.wdata[`STM_IADDR_RD];
         end
      end
   end

   // Indirect access runs the cycle after the address write
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         busy_reg <= 1'b0;
      end else begin
         busy_reg <= iaddr_wr;
      end
   end

   // Indirect data register and buffer reads
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         idata_reg <= 8'h00;
      end else if (busy_reg && irw_reg) begin
         if (ctrl_reg[`STM_CTRL_RXSEL]) begin
            idata_reg <= iaddr_reg[`STM_IADDR_PAGE] ?
                         exp_mem[iaddr_reg[5:0]] :
                         cap_mem[iaddr_reg[5:0]];
         end else if (!iaddr_reg[`STM_IADDR_PAGE]) begin
            idata_reg <= tx_mem[iaddr_reg[5:0]];
         end
      end else if (cpu_req.wr && cpu_req.addr == `STM_OFS_IDATA) begin
         idata_reg <= cpu_req.wdata;
      end
   end

   // Buffer writes from processor and receive stream
   always_ff @(posedge clk_sys) begin
      if (busy_reg && !irw_reg) begin
         if (ctrl_reg[`STM_CTRL_RXSEL]) begin
            if (iaddr_reg[`STM_IADDR_PAGE]) begin
               exp_mem[iaddr_reg[5:0]] <= idata_reg;
            end
         end else if (!iaddr_reg[`STM_IADDR_PAGE]) begin
            tx_mem[iaddr_reg[5:0]] <= idata_reg;
         end
      end
      if (byte_in) begin
         cap_mem[wslot] <= rx_trace.data;
      end
   end

   // Receive write pointer and message difference tracking
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         wptr_reg     <= 6'h00;
         prev1_reg    <= 8'h00;
         prev2_reg    <= 8'h00;
         msg_diff_reg <= 1'b0;
      end else if (byte_in) begin
         wptr_reg     <= ptr_inc(wslot, len_short);
         prev1_reg    <= rx_trace.data;
         prev2_reg    <= prev1_reg;
         msg_diff_reg <= msg_end ? 1'b0 : !msg_same;
      end
   end

   // Persistence counters
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         same_cnt_reg <= 3'd0;
         diff_cnt_reg <= 3'd0;
      end else if (msg_end) begin
         same_cnt_reg <= same_cnt_next;
         diff_cnt_reg <= diff_cnt_next;
      end
   end

   // Acceptance and mismatch state
   // Mismatch freezes once a differing byte overwrites the accepted page
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         accepted_reg <= 1'b0;
         mismatch_reg <= 1'b0;
      end else begin
         if (accept_now) begin
            accepted_reg <= 1'b1;
         end else if (byte_in && !msg_same) begin
            accepted_reg <= 1'b0;
         end
         if (accepted_reg) begin
            mismatch_reg <= mismatch_next;
         end
      end
   end

   // Stable and unstable state
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         stab_reg <= stm_pkg::STM_STABLE;
      end else if (un_enter) begin
         stab_reg <= stm_pkg::STM_UNSTABLE;
      end else if (un_leave) begin
         stab_reg <= stm_pkg::STM_STABLE;
      end
   end

   // Change flags; a new event wins over the read clear
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         mm_flag_reg <= 1'b0;
         un_flag_reg <= 1'b0;
      end else begin
         if (mm_change) begin
            mm_flag_reg <= 1'b1;
         end else if (stat_rd) begin
            mm_flag_reg <= 1'b0;
         end
         if (un_enter || un_leave) begin
            un_flag_reg <= 1'b1;
         end else if (stat_rd) begin
            un_flag_reg <= 1'b0;
         end
      end
   end

   // Interrupt output gated by the enables
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         irq_n_out <= 1'b1;
      end else begin
         irq_n_out <= !((mm_flag_reg && ctrl_reg[`STM_CTRL_MMIE]) ||
                        (un_flag_reg && ctrl_reg[`STM_CTRL_UNIE]));
      end
   end

   // Processor read data
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         cpu_rdata <= 8'h00;
      end else if (cpu_req.rd) begin
         unique case (cpu_req.addr)
            `STM_OFS_CTRL:  cpu_rdata <= ctrl_reg;
            `STM_OFS_STAT:  cpu_rdata <= {busy_reg, 3'b000, un_flag_reg,
                                          stab_reg == stm_pkg::STM_UNSTABLE,
                                          mm_flag_reg, mismatch_reg};
            `STM_OFS_IADDR: cpu_rdata <= {irw_reg, iaddr_reg};
            `STM_OFS_IDATA: cpu_rdata <= idata_reg;
            default:        cpu_rdata <= 8'h00;
         endcase
      end
   end

   // Transmit byte source, one per inserter request
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         tptr_reg             <= 6'h00;
         tx_overhead_inserter <= '0;
      end else begin
         tx_overhead_inserter.valid <= tx_req;
         if (tx_req) begin
            tx_overhead_inserter.data <= ctrl_reg[`STM_CTRL_TXNULL] ?
                                         8'h00 : tx_mem[tptr_reg];
            tptr_reg <= ptr_inc(tptr_reg, len_short);
         end
      end
   end

endmodule : stm_trace_ctrl

// ===== stm_trace_sva.sv
// Port checker for the trace block
// Assumes clk_sys and the async rst of the top module
`timescale 1ns/100ps
module stm_trace_sva (
   input wire logic                  clk_sys,
   input wire logic                  rst,
   input wire stm_pkg::stm_cpu_req_t cpu_req,
   input wire logic [7:0]            cpu_rdata,
   input wire stm_pkg::stm_byte_t    rx_trace,
   input wire logic                  tx_req,
   input wire stm_pkg::stm_byte_t    tx_overhead_inserter,
   input wire logic                  irq_n_out
);
   logic [7:0] ctrl_q;
   // Shadow of the control register
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst)
         ctrl_q <= 8'h04;
      else if (cpu_req.wr && cpu_req.addr == 8'h38)
         ctrl_q <= {1'b0, cpu_req.wdata[6:0]};
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence stat_rd;
      cpu_req.rd && cpu_req.addr == 8'h39;
   endsequence
   sequence rx_quiet;
      !rx_trace.valid && !cpu_req.wr;
   endsequence
   a_tx_answer: assert property (
      tx_req |=> tx_overhead_inserter.valid) else $error("no tx byte");
   a_tx_quiet: assert property (
      !tx_req |=> !tx_overhead_inserter.valid) else $error("stray tx byte");
   a_tx_hold: assert property (
      !tx_req |=> $stable(tx_overhead_inserter.data))
      else $error("tx byte moved");
   a_tx_null: assert property (
      tx_req && ctrl_q[2] && !cpu_req.wr |=> tx_overhead_inserter.data == 8'h00)
      else $error("null not zero");
   a_irq_masked: assert property (
      ctrl_q[5:4] == 2'b00 |=> irq_n_out) else $error("masked irq");
   a_stat_clear: assert property (
      rx_quiet [*3] ##0 stat_rd ##1 rx_quiet |=> irq_n_out)
      else $error("irq kept after status read");
   a_ctrl_read: assert property (
      cpu_req.rd && !cpu_req.wr && cpu_req.addr == 8'h38 |=> cpu_rdata == ctrl_q)
      else $error("control readback");
   a_rdata_hold: assert property (
      !cpu_req.rd |=> $stable(cpu_rdata)) else $error("read data moved");
   a_unmapped_zero: assert property (
      cpu_req.rd && cpu_req.addr[7:2] != 6'b001110 |=> cpu_rdata == 8'h00)
      else $error("unmapped read");
endmodule : stm_trace_sva
bind stm_trace_ctrl stm_trace_sva u_sva (.clk_sys(clk_sys), .rst(rst),
   .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .rx_trace(rx_trace),
   .tx_req(tx_req), .tx_overhead_inserter(tx_overhead_inserter),
   .irq_n_out(irq_n_out));

// ===== stm_far_end.sv
// Receive line model sending 16-byte and 64-byte trace messages
// Assumes one byte per frame with a gap of idle cycles after each
`timescale 1ns/100ps
module stm_far_end (
   input  wire logic         clk_sys,
   output stm_pkg::stm_byte_t rx_trace
);
   initial rx_trace = '0;
   // Byte 0 carries the marker bit; idle line shows the inverse byte
   task automatic send(input logic [7:0] k, input int rot, input int gap);
      send_len(k, rot, gap, 16);
   endtask : send
   // Long messages start with k and end in CR then LF
   task automatic send_len(input logic [7:0] k, input int rot,
                           input int gap, input int len);
      int         idx;
      logic [7:0] b;
      for (int i = 0; i < len; i++) begin
         idx = (i + rot) % len;
         if (idx == 0)
            b = (len == 16) ? (8'h80 | k) : k;
         else if (len != 16 && idx == len - 2)
            b = 8'h0d;
         else if (len != 16 && idx == len - 1)
            b = 8'h0a;
         else
            b = 8'(idx);
         @(posedge clk_sys);
         rx_trace <= '{valid: 1'b1, data: b};
         @(posedge clk_sys);
         rx_trace <= '{valid: 1'b0, data: ~b};
         repeat (gap) @(posedge clk_sys);
      end
   endtask : send_len
endmodule : stm_far_end

// ===== tb.sv
// Self-checking bench for the trace block
// Assumes stm_far_end feeds the receive stream
`timescale 1ns/100ps
module tb;
   typedef struct {logic [7:0] addr; logic [7:0] wdata;
                   logic [7:0] rdata;} stm_row_t;
   logic                  clk_sys;
   logic                  rst;
   stm_pkg::stm_cpu_req_t cpu_req;
   logic [7:0]            cpu_rdata;
   stm_pkg::stm_byte_t    rx_trace;
   logic                  tx_req;
   stm_pkg::stm_byte_t    tx_byte;
   logic                  irq_n_out;
   logic [7:0]            rd_val;
   int                    bad_count = 0;
   int                    check_count = 0;
   stm_row_t              rows [4] = '{'{8'h38, 8'hff, 8'h7f},
      '{8'h38, 8'h00, 8'h00}, '{8'h40, 8'h55, 8'h00}, '{8'h3c, 8'haa, 8'h00}};
   stm_trace_ctrl #(.MSG_DEPTH(64)) dut (.clk_sys(clk_sys), .rst(rst),
      .cpu_req(cpu_req), .cpu_rdata(cpu_rdata), .rx_trace(rx_trace),
      .tx_req(tx_req), .tx_overhead_inserter(tx_byte),
      .irq_n_out(irq_n_out));
   stm_far_end far (.clk_sys(clk_sys), .rx_trace(rx_trace));
   initial begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      cpu_req <= '{wr: wr, rd: !wr, addr: a, wdata: d};
      @(posedge clk_sys);
      cpu_req <= '0;
      #1 rd_val = cpu_rdata;
   endtask : bus
   task automatic ind(input logic wr, input logic [7:0] a, input logic [7:0] d);
      if (wr)
         bus(1'b1, 8'h3b, d);
      bus(1'b1, 8'h3a, {!wr, a[6:0]});
      repeat (2) @(posedge clk_sys);
      if (!wr)
         bus(1'b0, 8'h3b, 8'h00);
   endtask : ind
   task automatic tx_get();
      @(posedge clk_sys);
      tx_req <= 1'b1;
      @(posedge clk_sys);
      tx_req <= 1'b0;
      #1 check({7'h0, tx_byte.valid}, 8'h01);
      rd_val = tx_byte.data;
   endtask : tx_get
   task automatic irq_is(input logic [7:0] exp);
      repeat (4) @(posedge clk_sys);
      #1 check({7'h0, irq_n_out}, exp);
   endtask : irq_is
   initial begin
      repeat (20000) @(posedge clk_sys);
      bad_count++;
      test_done();
   end
   initial begin
      cpu_req = '0;
      tx_req = 1'b0;
      rst = 1'b1;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b0, 8'h38, 8'h00);
      check(rd_val, 8'h04);
      foreach (rows[i]) begin
         bus(1'b1, rows[i].addr, rows[i].wdata);
         bus(1'b0, rows[i].addr, 8'h00);
         check(rd_val, rows[i].rdata);
      end
      bus(1'b1, 8'h38, 8'h05);
      for (int i = 0; i < 16; i++)
         ind(1'b1, 8'(i), 8'h30 + 8'(i));
      ind(1'b1, 8'h40, 8'hff);
      ind(1'b0, 8'h00, 8'h00);
      check(rd_val, 8'h30);
      bus(1'b1, 8'h38, 8'h01);
      for (int i = 0; i < 18; i++) begin
         tx_get();
         check(rd_val, 8'h30 + 8'(i % 16));
      end
      bus(1'b1, 8'h38, 8'h51);
      for (int i = 0; i < 16; i++)
         ind(1'b1, 8'h40 + 8'(i), 8'h00);
      far.send(8'h01, 5, 0);
      repeat (2) far.send(8'h01, 0, 3);
      irq_is(8'h01);
      far.send(8'h01, 0, 0);
      irq_is(8'h00);
      bus(1'b0, 8'h39, 8'h00);
      check(rd_val & 8'h83, 8'h03);
      bus(1'b0, 8'h39, 8'h00);
      check(rd_val & 8'h83, 8'h01);
      check({7'h0, irq_n_out}, 8'h01);
      ind(1'b0, 8'h00, 8'h00);
      check(rd_val, 8'h81);
      bus(1'b1, 8'h38, 8'h61);
      for (int k = 2; k < 8; k++) begin
         far.send(8'(k), 0, 0);
         irq_is((k == 7) ? 8'h00 : 8'h01);
      end
      bus(1'b0, 8'h39, 8'h00);
      check(rd_val & 8'h0c, 8'h0c);
      repeat (2) far.send(8'h07, 0, 0);
      irq_is(8'h00);
      bus(1'b0, 8'h39, 8'h00);
      check(rd_val & 8'h0c, 8'h08);
      bus(1'b1, 8'h38, 8'h40);
      far.send_len(8'h4b, 5, 0, 64);
      ind(1'b0, 8'h00, 8'h00);
      check(rd_val, 8'h4b);
      bus(1'b1, 8'h38, 8'h43);
      far.send(8'h02, 0, 0);
      ind(1'b0, 8'h00, 8'h00);
      check(rd_val, 8'h0b);
      for (int i = 0; i < 16; i++)
         ind(1'b1, 8'h40 + 8'(i), (i == 0) ? 8'h83 : 8'(i));
      bus(1'b1, 8'h38, 8'h59);
      repeat (4) far.send(8'h03, 0, 0);
      irq_is(8'h01);
      far.send(8'h03, 0, 0);
      irq_is(8'h00);
      bus(1'b0, 8'h39, 8'h00);
      check(rd_val & 8'h03, 8'h02);
      @(posedge clk_sys);
      rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 check(tx_byte.data, 8'h00);
      check({7'h0, irq_n_out}, 8'h01);
      @(posedge clk_sys);
      rst <= 1'b0;
      bus(1'b0, 8'h38, 8'h00);
      check(rd_val, 8'h04);
      bus(1'b1, 8'h38, 8'h01);
      tx_get();
      check(rd_val, 8'h30);
      bus(1'b1, 8'h38, 8'h05);
      tx_get();
      check(rd_val, 8'h00);
      test_done();
   end
endmodule : tb
